// file: include/cfah_consts.vh
// Overview of operation
// - pin unlock: P1 must be 00, Lc absent or 10; secret then new PIN.
// - a successful suspend marks the target file as deactivated.
// - suspend runs only when the suspend access condition of the file holds.
// - successful suspend or resume makes the target the current elementary file.
// - a failed suspend or resume leaves current elementary and dedicated file unchanged.
// - without status byte or with b7 clear, deactivated file allows only select and resume.
// - with status byte b7 set, a deactivated file stays readable and updatable.
// - selection P1: 00 by id, 08 path from root, 09 path from current dedicated file.
// - P2 must be 00; P1=P2=00 without data acts on current elementary file.
// - a successful resume clears the deactivated mark, gated by its access condition.
// - odd form data is wrapped in tag 73 or tag 53 objects.
// - odd form data comes in blocks of at most 255 bytes, reassembled in order.
// - incomplete data answers 63 F1 per block; final segment answers 62 F3.
// - response is computed only on the first response block request.
// - response segments answer 62 F1 while more remain, 90 00 with the last.
// - resend request repeats the previous data or response block.
// - odd form is optional and can be switched off.
// - P1 b8..b6 code the chaining step of the odd form.
`ifndef CFAH_CONSTS_VH
`define CFAH_CONSTS_VH
`define CFAH_KIND_PIN 3'h0
`define CFAH_KIND_SUSPEND 3'h1
`define CFAH_KIND_RESUME 3'h2
`define CFAH_KIND_AUTH_EVEN 3'h3
`define CFAH_KIND_AUTH_ODD 3'h4
`define CFAH_PIN_LC 8'h10
`define CFAH_SEL_FID 8'h00
`define CFAH_SEL_PATH_ROOT 8'h08
`define CFAH_SEL_PATH_DF 8'h09
`define CFAH_STEP_DATA_FIRST 3'h4
`define CFAH_STEP_DATA_NEXT 3'h0
`define CFAH_STEP_DATA_RESEND 3'h2
`define CFAH_STEP_RSP_FIRST 3'h5
`define CFAH_STEP_RSP_NEXT 3'h1
`define CFAH_STEP_RSP_RESEND 3'h3
`define CFAH_TAG_TLV 8'h73
`define CFAH_TAG_PLAIN 8'h53
`define CFAH_LEN_1B 8'h81
`define CFAH_SW_OK 16'h9000
`define CFAH_SW_DATA_MORE 16'h63F1
`define CFAH_SW_DATA_DONE 16'h62F3
`define CFAH_SW_RSP_MORE 16'h62F1
`define CFAH_SW_BAD_P1P2 16'h6A86
`define CFAH_SW_BAD_LEN 16'h6700
`define CFAH_SW_BAD_DATA 16'h6A80
`define CFAH_SW_NOT_FOUND 16'h6A82
`define CFAH_SW_SECURITY 16'h6982
`define CFAH_SW_SEQUENCE 16'h6985
`define CFAH_SW_NO_EF 16'h6986
`define CFAH_SW_BAD_INS 16'h6D00
`define CFAH_FIFO_DEPTH 16
`define CFAH_ACC_SELECT 2'h0
`define CFAH_ACC_RESUME 2'h1
`define CFAH_ACC_RW 2'h2
`endif

// file: hw/cfah_fifo.v
`timescale 1ns/1ps
`default_nettype none
module cfah_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // cfah_fifo
`default_nettype wire

// file: hw/cfah_cmd_handler.v
`timescale 1ns/1ps
`default_nettype none
`include "cfah_consts.vh"
module cfah_cmd_handler (
  input wire clk_sys,
  input wire reset,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [2:0] cmd_kind,
  input wire [7:0] cmd_p1,
  input wire [7:0] cmd_p2,
  input wire [7:0] cmd_lc,
  input wire cmd_lc_present,
  input wire [7:0] cmd_le,
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_byte,
  output reg rsp_valid,
  output reg [15:0] rsp_sw,
  output reg out_valid,
  input wire out_ready,
  output reg [7:0] out_byte,
  output reg pin_unlock_req,
  output reg pin_retry_query,
  output reg [4:0] pin_key_ref,
  output reg [63:0] pin_unblock_secret,
  output reg [63:0] pin_new_value,
  input wire pin_done,
  input wire [15:0] pin_sw,
  output reg resolve_req,
  output reg [1:0] resolve_mode,
  output reg [15:0] resolve_fid,
  input wire resolve_done,
  input wire resolve_found,
  input wire [2:0] resolve_index,
  input wire [7:0] ac_suspend_ok,
  input wire [7:0] ac_resume_ok,
  input wire [7:0] file_status_present,
  input wire [7:0] file_status_b7,
  output reg [7:0] file_deactivated,
  input wire sel_valid,
  input wire [2:0] sel_ef,
  input wire [2:0] sel_df,
  output reg [2:0] cur_ef,
  output reg cur_ef_valid,
  output reg [2:0] cur_df,
  input wire [2:0] access_file,
  input wire [1:0] access_op,
  output wire access_ok,
  input wire auth_odd_enable,
  output reg auth_wr_valid,
  output reg [15:0] auth_wr_addr,
  output reg [7:0] auth_wr_byte,
  output reg auth_start,
  output reg [7:0] auth_key_ref,
  input wire auth_done,
  input wire [15:0] auth_rsp_len,
  output reg [15:0] auth_rd_addr,
  input wire [7:0] auth_rd_data
);
  // ------------------------------------------------------------------
  // states
  // ------------------------------------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_RX = 4'h1;
  localparam S_RESOLVE = 4'h2;
  localparam S_FILE = 4'h3;
  localparam S_PIN = 4'h4;
  localparam S_AUTH = 4'h5;
  localparam S_CHK = 4'h6;
  localparam S_SEG = 4'h7;
  localparam S_RD = 4'h8;
  localparam S_WAIT = 4'h9;
  localparam S_LOAD = 4'hA;
  localparam S_OUT = 4'hB;
  localparam S_END = 4'hC;

  localparam CH_IDLE = 3'h0;
  localparam CH_DATA = 3'h1;
  localparam CH_READY = 3'h2;
  localparam CH_RESP = 3'h3;
  localparam CH_RDONE = 3'h4;

  // total object length from the tag-length header
  function [16:0] tlv_total;
    input [7:0] l1;
    input [7:0] l2;
    input [7:0] l3;
    begin
      if (!l1[7]) begin
        tlv_total = {9'h000, l1} + 17'h00002;
      end else if (l1 == `CFAH_LEN_1B) begin
        tlv_total = {9'h000, l2} + 17'h00003;
      end else begin
        tlv_total = {1'b0, l2, l3} + 17'h00004;
      end
    end
  endfunction

  reg [3:0] state;
  reg [2:0] chain;
  reg [2:0] kind;
  reg [7:0] p1;
  reg [7:0] lc;
  reg [7:0] le;
  reg discard;
  reg bad_tag;
  reg [15:0] err_sw;
  reg [7:0] rx_cnt;
  reg [15:0] blk_base;
  reg [15:0] data_end;
  reg [15:0] data_prev;
  reg [7:0] len1;
  reg [7:0] len2;
  reg [7:0] len3;
  reg [2:0] tgt;
  reg [15:0] rsp_total;
  reg [15:0] rsp_base;
  reg [15:0] rsp_prev;
  reg [15:0] tx_len;
  reg [15:0] tx_cnt;

  wire f_valid;
  wire f_ready;
  wire [7:0] f_byte;
  wire [2:0] step;
  wire [15:0] pos;
  wire rx_last;
  wire [2:0] hdr_len;
  wire [16:0] total;
  wire data_complete;
  wire [15:0] remaining;
  wire [15:0] le_n;
  wire [15:0] seg;
  wire sel_ok;
  wire is_file;

  // ------------------------------------------------------------------
  // command data buffer
  // ------------------------------------------------------------------
  cfah_fifo #(
    .W(8),
    .D(`CFAH_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_byte),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_byte)
  );

  assign cmd_ready = (state == S_IDLE);
  assign f_ready = (state == S_RX);
  assign step = cmd_p1[7:5];
  assign pos = blk_base + {8'h00, rx_cnt};
  assign rx_last = (rx_cnt == lc - 8'h01);
  assign hdr_len = len1[7] ? ((len1 == `CFAH_LEN_1B) ? 3'h3 : 3'h4) : 3'h2;
  assign total = tlv_total(len1, len2, len3);
  assign data_complete = (data_end >= {13'h0000, hdr_len}) &&
                         ({1'b0, data_end} >= total);
  assign remaining = rsp_total - rsp_base;
  assign le_n = (le == 8'h00) ? 16'h0100 : {8'h00, le};
  assign seg = (remaining > le_n) ? le_n : remaining;
  assign sel_ok = (cmd_p1 == `CFAH_SEL_FID) || (cmd_p1 == `CFAH_SEL_PATH_ROOT) ||
                  (cmd_p1 == `CFAH_SEL_PATH_DF);
  assign is_file = (cmd_kind == `CFAH_KIND_SUSPEND) || (cmd_kind == `CFAH_KIND_RESUME);

  // deactivated files: only select and resume, unless b7 keeps read/update
  assign access_ok = !file_deactivated[access_file] ||
                     (access_op == `CFAH_ACC_SELECT) || (access_op == `CFAH_ACC_RESUME) ||
                     ((access_op == `CFAH_ACC_RW) && file_status_present[access_file] &&
                      file_status_b7[access_file]);

  // ------------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      state <= S_IDLE;
      chain <= CH_IDLE;
      kind <= 3'h0;
      p1 <= 8'h00;
      lc <= 8'h00;
      le <= 8'h00;
      discard <= 1'b0;
      bad_tag <= 1'b0;
      err_sw <= 16'h0000;
      rx_cnt <= 8'h00;
      blk_base <= 16'h0000;
      data_end <= 16'h0000;
      data_prev <= 16'h0000;
      len1 <= 8'h00;
      len2 <= 8'h00;
      len3 <= 8'h00;
      tgt <= 3'h0;
      rsp_total <= 16'h0000;
      rsp_base <= 16'h0000;
      rsp_prev <= 16'h0000;
      tx_len <= 16'h0000;
      tx_cnt <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_sw <= 16'h0000;
      out_valid <= 1'b0;
      out_byte <= 8'h00;
      pin_unlock_req <= 1'b0;
      pin_retry_query <= 1'b0;
      pin_key_ref <= 5'h00;
      pin_unblock_secret <= 64'h0000000000000000;
      pin_new_value <= 64'h0000000000000000;
      resolve_req <= 1'b0;
      resolve_mode <= 2'h0;
      resolve_fid <= 16'h0000;
      file_deactivated <= 8'h00;
      cur_ef <= 3'h0;
      cur_ef_valid <= 1'b0;
      cur_df <= 3'h0;
      auth_wr_valid <= 1'b0;
      auth_wr_addr <= 16'h0000;
      auth_wr_byte <= 8'h00;
      auth_start <= 1'b0;
      auth_key_ref <= 8'h00;
      auth_rd_addr <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      pin_unlock_req <= 1'b0;
      pin_retry_query <= 1'b0;
      resolve_req <= 1'b0;
      auth_wr_valid <= 1'b0;
      auth_start <= 1'b0;
      if (sel_valid) begin
        cur_ef <= sel_ef;
        cur_ef_valid <= 1'b1;
        cur_df <= sel_df;
      end
      case (state)
        S_IDLE: begin
          if (cmd_valid) begin
            kind <= cmd_kind;
            p1 <= cmd_p1;
            lc <= cmd_lc_present ? cmd_lc : 8'h00;
            le <= cmd_le;
            auth_key_ref <= cmd_p2;
            pin_key_ref <= cmd_p2[4:0];
            resolve_mode <= cmd_p1[3] ? {1'b1, cmd_p1[0]} : 2'h0;
            rx_cnt <= 8'h00;
            blk_base <= 16'h0000;
            discard <= 1'b0;
            bad_tag <= 1'b0;
            err_sw <= 16'h0000;
            state <= cmd_lc_present ? S_RX : S_END;
            if (cmd_lc_present && cmd_lc == 8'h00) begin
              err_sw <= `CFAH_SW_BAD_LEN;
              state <= S_END;
            end else if (cmd_kind == `CFAH_KIND_PIN) begin
              if (cmd_p1 != 8'h00) begin
                discard <= 1'b1;
                err_sw <= `CFAH_SW_BAD_P1P2;
              end else if (cmd_lc_present && cmd_lc != `CFAH_PIN_LC) begin
                discard <= 1'b1;
                err_sw <= `CFAH_SW_BAD_LEN;
              end else if (!cmd_lc_present) begin
                pin_retry_query <= 1'b1;
                state <= S_PIN;
              end
            end else if (is_file) begin
              if (cmd_p2 != 8'h00 || !sel_ok) begin
                discard <= 1'b1;
                err_sw <= `CFAH_SW_BAD_P1P2;
              end else if (!cmd_lc_present && cmd_p1 == `CFAH_SEL_FID) begin
                if (cur_ef_valid) begin
                  tgt <= cur_ef;
                  state <= S_FILE;
                end else begin
                  err_sw <= `CFAH_SW_NO_EF;
                end
              end else if (!cmd_lc_present) begin
                err_sw <= `CFAH_SW_BAD_LEN;
              end
            end else if (cmd_kind == `CFAH_KIND_AUTH_EVEN) begin
              if (cmd_p1 != 8'h00) begin
                discard <= 1'b1;
                err_sw <= `CFAH_SW_BAD_P1P2;
              end else if (!cmd_lc_present) begin
                err_sw <= `CFAH_SW_BAD_LEN;
              end
            end else if (cmd_kind == `CFAH_KIND_AUTH_ODD && auth_odd_enable) begin
              case (step)
                `CFAH_STEP_DATA_FIRST: begin
                  if (!cmd_lc_present) begin
                    err_sw <= `CFAH_SW_BAD_LEN;
                  end else begin
                    chain <= CH_DATA;
                    data_end <= 16'h0000;
                    data_prev <= 16'h0000;
                  end
                end
                `CFAH_STEP_DATA_NEXT: begin
                  if (chain != CH_DATA || !cmd_lc_present) begin
                    discard <= 1'b1;
                    err_sw <= `CFAH_SW_SEQUENCE;
                  end else begin
                    blk_base <= data_end;
                    data_prev <= data_end;
                  end
                end
                `CFAH_STEP_DATA_RESEND: begin
                  if ((chain != CH_DATA && chain != CH_READY) || !cmd_lc_present) begin
                    discard <= 1'b1;
                    err_sw <= `CFAH_SW_SEQUENCE;
                  end else begin
                    blk_base <= data_prev;
                    chain <= CH_DATA;
                  end
                end
                `CFAH_STEP_RSP_FIRST: begin
                  if (chain != CH_READY || cmd_lc_present) begin
                    discard <= 1'b1;
                    err_sw <= `CFAH_SW_SEQUENCE;
                  end else begin
                    auth_start <= 1'b1;
                    rsp_base <= 16'h0000;
                    state <= S_AUTH;
                  end
                end
                `CFAH_STEP_RSP_NEXT: begin
                  if (chain != CH_RESP || cmd_lc_present) begin
                    discard <= 1'b1;
                    err_sw <= `CFAH_SW_SEQUENCE;
                  end else begin
                    rsp_prev <= rsp_base;
                    rsp_base <= rsp_base + tx_len;
                    state <= S_SEG;
                  end
                end
                `CFAH_STEP_RSP_RESEND: begin
                  if ((chain != CH_RESP && chain != CH_RDONE) || cmd_lc_present) begin
                    discard <= 1'b1;
                    err_sw <= `CFAH_SW_SEQUENCE;
                  end else begin
                    state <= S_SEG;
                  end
                end
                default: begin
                  discard <= 1'b1;
                  err_sw <= `CFAH_SW_BAD_P1P2;
                end
              endcase
            end else begin
              discard <= 1'b1;
              err_sw <= `CFAH_SW_BAD_INS;
            end
          end
        end
        S_RX: begin
          if (f_valid) begin
            rx_cnt <= rx_cnt + 8'h01;
            if (!discard) begin
              if (kind == `CFAH_KIND_PIN) begin
                {pin_unblock_secret, pin_new_value} <=
                  {pin_unblock_secret[55:0], pin_new_value, f_byte};
              end else if (kind == `CFAH_KIND_AUTH_EVEN || kind == `CFAH_KIND_AUTH_ODD) begin
                auth_wr_valid <= 1'b1;
                auth_wr_addr <= pos;
                auth_wr_byte <= f_byte;
              end else begin
                resolve_fid <= {resolve_fid[7:0], f_byte};
              end
              if (kind == `CFAH_KIND_AUTH_ODD) begin
                if (pos == 16'h0000 && f_byte != `CFAH_TAG_TLV &&
                    f_byte != `CFAH_TAG_PLAIN) begin
                  bad_tag <= 1'b1;
                end
                if (pos == 16'h0001) len1 <= f_byte;
                if (pos == 16'h0002) len2 <= f_byte;
                if (pos == 16'h0003) len3 <= f_byte;
              end
            end
            if (rx_last) begin
              if (discard) begin
                state <= S_END;
              end else if (kind == `CFAH_KIND_PIN) begin
                pin_unlock_req <= 1'b1;
                state <= S_PIN;
              end else if (kind == `CFAH_KIND_AUTH_EVEN) begin
                auth_start <= 1'b1;
                rsp_base <= 16'h0000;
                state <= S_AUTH;
              end else if (kind == `CFAH_KIND_AUTH_ODD) begin
                data_end <= blk_base + {8'h00, lc};
                state <= S_CHK;
              end else begin
                resolve_req <= 1'b1;
                state <= S_RESOLVE;
              end
            end
          end
        end
        S_CHK: begin
          if (bad_tag) begin
            chain <= CH_IDLE;
            err_sw <= `CFAH_SW_BAD_DATA;
          end else if (data_complete) begin
            chain <= CH_READY;
            err_sw <= `CFAH_SW_DATA_DONE;
          end else begin
            err_sw <= `CFAH_SW_DATA_MORE;
          end
          state <= S_END;
        end
        S_RESOLVE: begin
          if (resolve_done) begin
            if (resolve_found) begin
              tgt <= resolve_index;
              state <= S_FILE;
            end else begin
              err_sw <= `CFAH_SW_NOT_FOUND;
              state <= S_END;
            end
          end
        end
        S_FILE: begin
          if (kind == `CFAH_KIND_SUSPEND ? ac_suspend_ok[tgt] : ac_resume_ok[tgt]) begin
            file_deactivated[tgt] <= (kind == `CFAH_KIND_SUSPEND);
            cur_ef <= tgt;
            cur_ef_valid <= 1'b1;
            err_sw <= `CFAH_SW_OK;
          end else begin
            err_sw <= `CFAH_SW_SECURITY;
          end
          state <= S_END;
        end
        S_PIN: begin
          if (pin_done) begin
            err_sw <= pin_sw;
            state <= S_END;
          end
        end
        S_AUTH: begin
          if (auth_done) begin
            rsp_total <= auth_rsp_len;
            rsp_prev <= 16'h0000;
            state <= S_SEG;
          end
        end
        S_SEG: begin
          tx_len <= seg;
          tx_cnt <= 16'h0000;
          state <= (seg == 16'h0000) ? S_END : S_RD;
          if (kind == `CFAH_KIND_AUTH_ODD && remaining > le_n) begin
            chain <= CH_RESP;
            err_sw <= `CFAH_SW_RSP_MORE;
          end else begin
            chain <= (kind == `CFAH_KIND_AUTH_ODD) ? CH_RDONE : chain;
            err_sw <= `CFAH_SW_OK;
          end
        end
        S_RD: begin
          auth_rd_addr <= rsp_base + tx_cnt;
          state <= S_WAIT;
        end
        // the engine registers its read data one edge after the address
        S_WAIT: begin
          state <= S_LOAD;
        end
        S_LOAD: begin
          out_byte <= auth_rd_data;
          out_valid <= 1'b1;
          state <= S_OUT;
        end
        S_OUT: begin
          if (out_ready) begin
            out_valid <= 1'b0;
            tx_cnt <= tx_cnt + 16'h0001;
            state <= (tx_cnt + 16'h0001 == tx_len) ? S_END : S_RD;
          end
        end
        S_END: begin
          rsp_valid <= 1'b1;
          rsp_sw <= err_sw;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // cfah_cmd_handler
`default_nettype wire

// file: verif/cfah_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cfah_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_sw,
  input wire logic sel_valid,
  input wire logic [2:0] cur_ef,
  input wire logic [7:0] file_deactivated,
  input wire logic [2:0] access_file,
  input wire logic [1:0] access_op,
  input wire logic access_ok,
  input wire logic [7:0] file_status_present,
  input wire logic [7:0] file_status_b7,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_p1,
  input wire logic [1:0] resolve_mode,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_byte
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  flag_set_a: assert property (
    |(file_deactivated & ~$past(file_deactivated)) |-> ##1 rsp_valid && rsp_sw == 16'h9000)
    else $error("flag set without success");
  flag_clear_a: assert property (
    |(~file_deactivated & $past(file_deactivated)) |-> ##1 rsp_valid && rsp_sw == 16'h9000)
    else $error("flag cleared without success");
  ef_follow_a: assert property (
    $changed(cur_ef) && !$past(sel_valid) |-> ##1 rsp_valid && rsp_sw == 16'h9000)
    else $error("current file moved without success");
  ef_keep_a: assert property (
    rsp_valid && rsp_sw != 16'h9000 && !$past(sel_valid) && !$past(sel_valid, 2)
    |-> cur_ef == $past(cur_ef, 2)) else $error("current file moved on failure");
  other_op_a: assert property (
    access_op == 2'h3 && file_deactivated[access_file] |-> !access_ok)
    else $error("deactivated file usable");
  rw_op_a: assert property (
    access_op == 2'h2 && file_deactivated[access_file]
    |-> access_ok == (file_status_present[access_file] && file_status_b7[access_file]))
    else $error("read update permission wrong");
  sel_mode_a: assert property (
    cmd_valid && cmd_ready && (cmd_p1 == 8'h08 || cmd_p1 == 8'h09)
    |=> resolve_mode == (($past(cmd_p1) == 8'h08) ? 2'h2 : 2'h3))
    else $error("selection mode wrong");
  out_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_byte)) else $error("byte not held");
endmodule // cfah_checker
bind cfah_cmd_handler cfah_checker u_chk (.*);
`default_nettype wire

// file: verif/cfah_backend_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfah_backend_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic pin_unlock_req,
  input wire logic pin_retry_query,
  input wire logic resolve_req,
  input wire logic [15:0] resolve_fid,
  input wire logic auth_start,
  input wire logic [15:0] auth_rd_addr,
  output logic pin_done,
  output logic [15:0] pin_sw,
  output logic resolve_done,
  output logic resolve_found,
  output logic [2:0] resolve_index,
  output logic auth_done,
  output logic [15:0] auth_rsp_len,
  output logic [7:0] auth_rd_data
);
  logic [3:0] pq = 0, rq = 0, aq = 0;
  logic [15:0] fid = 0;
  logic k = 0;
  always @(posedge clk_sys) begin
    pq <= {pq[2:0], pin_unlock_req | pin_retry_query};
    rq <= {rq[2:0], resolve_req};
    aq <= {aq[2:0], auth_start};
    if (resolve_req) fid <= resolve_fid;
    if (pin_unlock_req | pin_retry_query) k <= pin_unlock_req;
    auth_rd_data <= auth_rd_addr[7:0] ^ 8'hA5;
  end
  assign pin_done = slow ? pq[3] : pq[0];
  assign resolve_done = slow ? rq[3] : rq[0];
  assign auth_done = slow ? aq[3] : aq[0];
  assign pin_sw = pin_done ? (k ? 16'h9000 : 16'h63C5) : 16'hFFFF;
  assign resolve_found = resolve_done & (fid < 16'h0008);
  assign resolve_index = resolve_done ? fid[2:0] : ~fid[2:0];
  assign auth_rsp_len = auth_done ? 16'h0005 : 16'hFFFF;
endmodule // cfah_backend_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 0, reset = 1, cmd_valid = 0, cmd_lc_present = 0, in_valid = 0;
  logic out_ready = 0, sel_valid = 0, auth_odd_enable = 0, slow = 0;
  logic [2:0] cmd_kind = 0, sel_ef = 0, sel_df = 0, access_file = 0;
  logic [1:0] access_op = 0;
  logic [7:0] cmd_p1 = 0, cmd_p2 = 0, cmd_lc = 0, cmd_le = 0, in_byte = 0;
  logic [7:0] ac_suspend_ok = 8'hFE, ac_resume_ok = 8'hFF, x_out = 0;
  logic [7:0] file_status_present = 8'h0C, file_status_b7 = 8'h08;
  logic [5:0] at [5] = '{6'h1D, 6'h1E, 6'h14, 6'h11, 6'h13};
  wire [15:0] rsp_sw, resolve_fid, auth_wr_addr, auth_rd_addr, pin_sw, auth_rsp_len;
  wire [63:0] pin_unblock_secret, pin_new_value;
  wire [7:0] out_byte, file_deactivated, auth_wr_byte, auth_key_ref, auth_rd_data;
  wire [4:0] pin_key_ref;
  wire [2:0] cur_ef, cur_df, resolve_index;
  wire [1:0] resolve_mode;
  wire cmd_ready, in_ready, rsp_valid, out_valid, pin_unlock_req, pin_retry_query, pin_done;
  wire resolve_req, resolve_done, resolve_found, cur_ef_valid, access_ok;
  wire auth_wr_valid, auth_start, auth_done;
  int n_errors = 0, n_compared = 0, n_out = 0, n_start = 0;
  cfah_cmd_handler u_dut (.*);
  cfah_backend_model u_far (.*);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    out_ready <= ~out_ready;
    if (out_valid && out_ready) begin
      n_out++;
      x_out ^= out_byte;
    end
    if (auth_start) n_start++;
  end
  task chk(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task ap(input [2:0] k, input [7:0] p1, p2, lc, le, input [127:0] d, input [15:0] sw);
    int i, t;
    n_out = 0;
    x_out = 0;
    cmd_valid <= 1;
    cmd_kind <= k;
    cmd_p1 <= p1;
    cmd_p2 <= p2;
    cmd_lc <= lc;
    cmd_le <= le;
    cmd_lc_present <= lc != 0;
    t = 0;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++t < 400);
    cmd_valid <= 0;
    for (i = 0; i < lc; i++) begin
      in_valid <= 1;
      in_byte <= d[8*(lc-1-i) +: 8];
      do @(posedge clk_sys); while (in_ready !== 1'b1 && ++t < 400);
    end
    in_valid <= 0;
    while (rsp_valid !== 1'b1 && ++t < 400) @(posedge clk_sys);
    if (t >= 400) begin
      n_errors++;
      tally_and_finish;
    end
    chk(rsp_sw, sw);
  endtask
  // ----------------------------------------
  // command sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    chk(file_deactivated, 0);
    ap(1, 0, 0, 0, 0, 0, 16'h6986);
    sel_valid <= 1;
    sel_ef <= 3;
    sel_df <= 5;
    @(posedge clk_sys);
    sel_valid <= 0;
    @(posedge clk_sys);
    ap(1, 0, 0, 0, 0, 0, 16'h9000);
    chk(file_deactivated, 8'h08);
    ap(1, 0, 0, 2, 0, 16'h0002, 16'h9000);
    chk({cur_ef_valid, cur_ef}, {1'b1, 3'h2});
    ap(1, 8'h08, 0, 4, 0, 32'h3F000000, 16'h6982);
    chk({cur_df, cur_ef}, {3'h5, 3'h2});
    foreach (at[i]) begin
      access_file <= at[i][5:3];
      access_op <= at[i][2:1];
      @(posedge clk_sys);
      chk(access_ok, at[i][0]);
    end
    ap(1, 8'h01, 0, 2, 0, 16'h0003, 16'h6A86);
    ap(2, 0, 8'h01, 0, 0, 0, 16'h6A86);
    slow <= 1;
    ap(2, 8'h09, 0, 2, 0, 16'h0003, 16'h9000);
    chk({cur_ef, file_deactivated}, {3'h3, 8'h04});
    ap(0, 0, 8'h01, 16, 0, 128'h0102030405060708_1112131415161718, 16'h9000);
    chk({pin_unblock_secret, pin_new_value}, 128'h0102030405060708_1112131415161718);
    chk(pin_key_ref, 5'h01);
    ap(0, 0, 8'h01, 0, 0, 0, 16'h63C5);
    ap(0, 0, 8'h01, 8, 0, 64'h1, 16'h6700);
    ap(0, 8'h01, 8'h01, 16, 0, 0, 16'h6A86);
    ap(4, 8'h80, 0, 3, 0, 24'h530311, 16'h6D00);
    auth_odd_enable <= 1;
    ap(4, 0, 0, 2, 0, 16'h2233, 16'h6985);
    ap(4, 8'h80, 0, 3, 0, 24'h110311, 16'h6A80);
    ap(4, 8'h80, 0, 3, 0, 24'h730311, 16'h63F1);
    ap(4, 0, 0, 2, 0, 16'h2233, 16'h62F3);
    ap(4, 8'h40, 0, 2, 0, 16'h2233, 16'h62F3);
    chk(n_start, 0);
    ap(4, 8'hA0, 0, 0, 3, 0, 16'h62F1);
    chk({n_start, n_out, x_out}, {32'd1, 32'd3, 8'hA6});
    ap(4, 8'h20, 0, 0, 3, 0, 16'h9000);
    ap(4, 8'h60, 0, 0, 3, 0, 16'h9000);
    chk({n_start, n_out, x_out}, {32'd1, 32'd2, 8'h07});
    ap(3, 0, 8'h81, 1, 2, 8'h55, 16'h9000);
    chk({n_out, x_out}, {32'd2, 8'h01});
    chk({auth_key_ref, auth_wr_addr, auth_wr_byte}, {8'h81, 16'h0000, 8'h55});
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
